// >>> trgs_top.sv
// trgs_top: coarse range counter, target hold register, range gate,
// acquisition modes and 32-return smoothing accumulator
// assumes echo, phase flags and tap bits arrive from outside the clock
// domain; bin tick and output ready come from logic on i_ref_clk
// Operation
// R01: decode thermometer phase flags to three fine bits
// R02: 21-bit hold register keeps or circulates serially
// R03: load coarse count high, fine range low six
// R04: hold keeps latest return until the next
// R05: add new range serially into the accumulator
// R06: then reduce hold by 102.4 m, clamp zero
// R07: ungated at startup and when target lost
// R08: lock gate after two returns within 51.2 m; code locks on an in-gate return 14 counts nearer to 1 farther
// R09: near targets open the gate at zero
// R10: gate start by 15-bit counter equality
// R11: sixteen-count gate; only in-gate returns accepted
// R12: miss counter clears on return, 64 wraps unlock
// R13: trial flag, lock on next in-gate return
// R14: advance flag gives early gate start indication
// R15: average first 32 returns of each bin
// R16: accumulator 26 bits wide, serial circulation
// R17: average from bit six; low five bits kept
// R18: bits ten to seven load and shift fast
// R19: free 15-bit coarse counter wraps to zero
// R20: hit counter saturates, blocks adds until bin tick
// R21: accumulator cleared at each bin start
`timescale 1ns/1ps
`include "trgs_defs.svh"
module trgs_top #(
  parameter int ACC_W = `TRGS_ACC_W,
  parameter int DEPTH = `TRGS_FIFO_DEPTH
) (
  input  wire logic                  i_ref_clk,          // 50 MHz
  input  wire logic                  i_rst,              // sync, high
  input  wire logic                  i_ce,               // clock enable
  input  wire logic                  i_phase_flag_a,     // pin
  input  wire logic                  i_phase_flag_b,     // pin
  input  wire logic                  i_phase_flag_c,     // pin
  input  wire logic                  i_phase_flag_d,     // pin
  input  wire logic [2:0]            i_fine_tap,         // tap cnt, pin
  input  wire logic                  i_echo,             // return, pin
  input  wire logic [14:0]           i_range_max,        // wrap count
  input  wire logic                  i_bin_tick,         // bin start
  input  wire logic                  i_avg_ready,        // reader ready
  output logic                       o_avg_valid,        // average out
  output logic [ACC_W-`TRGS_AVG_LSB-1:0] o_avg,          // sum / 32
  output logic [`TRGS_AVG_LSB-1:0]   o_avg_frac,         // sum bits 1-5
  output logic [14:0]                o_range_count,      // coarse cnt
  output logic                       o_range_wrap,       // wrap pulse
  output logic [20:0]                o_hold,             // hold reg
  output logic                       o_gate_open,        // gate level
  output logic                       o_trial_gate_flag,  // trial mode
  output logic                       o_gate_lock_flag,   // gated mode
  output logic                       o_gate_advance_flag,// early start
  output logic [2:0]                 o_fine_code,        // decoded
  output logic [5:0]                 o_hits,             // hit count
  output logic [6:0]                 o_miss              // miss count
);
  localparam int HW = `TRGS_HOLD_W;
  localparam int SW = $clog2(ACC_W);
  localparam int AL = `TRGS_AVG_LSB;

  generate
    if (ACC_W < HW + AL || ACC_W > 32) begin : g_bad_acc
      $error("trgs_top: ACC_W must lie between 26 and 32");  // [R16]
    end
  endgenerate

  // pin synchronisers: {echo, tap[2:0], d, c, b, a}
  logic [7:0] sync1_ff, sync2_ff, nxt_sync1, nxt_sync2;
  logic       echo_d_ff, nxt_echo_d;

  always_comb begin
    nxt_sync1  = sync1_ff;
    nxt_sync2  = sync2_ff;
    nxt_echo_d = echo_d_ff;
    if (i_ce) begin
      nxt_sync1  = {i_echo, i_fine_tap, i_phase_flag_d, i_phase_flag_c,
                    i_phase_flag_b, i_phase_flag_a};
      nxt_sync2  = sync1_ff;
      nxt_echo_d = sync2_ff[7];
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      sync1_ff  <= 8'h00;
      sync2_ff  <= 8'h00;
      echo_d_ff <= 1'h0;
    end else begin
      sync1_ff  <= nxt_sync1;
      sync2_ff  <= nxt_sync2;
      echo_d_ff <= nxt_echo_d;
    end
  end

  logic [2:0] fine_w;

  trgs_fine_dec u_dec (
    .i_phase_flag_a (sync2_ff[0]),
    .i_phase_flag_b (sync2_ff[1]),
    .i_phase_flag_c (sync2_ff[2]),
    .i_phase_flag_d (sync2_ff[3]),
    .o_code         (fine_w)
  );

  // core state
  trgs_pkg::trgs_state_e st_ff, nxt_st;
  logic [14:0]      cnt_ff, nxt_cnt, ref_ff, nxt_ref;
  logic             wrap_ff, nxt_wrap, adv_ff, nxt_adv;
  logic [4:0]       gate_ff, nxt_gate;
  logic             gopen_ff, nxt_gopen;
  logic             trial_ff, nxt_trial, lock_ff, nxt_lock;
  logic [6:0]       miss_ff, nxt_miss;
  logic [HW-1:0]    hold_ff, nxt_hold;
  logic [ACC_W-1:0] acc_ff, nxt_acc;
  logic             carry_ff, nxt_carry;
  logic [SW-1:0]    step_ff, nxt_step;
  logic [5:0]       hits_ff, nxt_hits;
  logic             bin_ff, nxt_bin;
  logic [2:0]       fine_ff, nxt_fine;

  logic       ret, accept, push, push_rdy, hb;
  logic [1:0] sum;

  always_comb begin
    nxt_st    = st_ff;
    nxt_cnt   = cnt_ff;
    nxt_ref   = ref_ff;
    nxt_wrap  = wrap_ff;
    nxt_adv   = adv_ff;
    nxt_gate  = gate_ff;
    nxt_gopen = gopen_ff;
    nxt_trial = trial_ff;
    nxt_lock  = lock_ff;
    nxt_miss  = miss_ff;
    nxt_hold  = hold_ff;
    nxt_acc   = acc_ff;
    nxt_carry = carry_ff;
    nxt_step  = step_ff;
    nxt_hits  = hits_ff;
    nxt_bin   = bin_ff;
    nxt_fine  = fine_ff;
    ret    = sync2_ff[7] & ~echo_d_ff;
    // a finished bin is handed on only between additions
    push   = bin_ff & (st_ff == trgs_pkg::ST_IDLE);
    accept = 1'h0;
    hb     = (step_ff < SW'(HW)) & hold_ff[0];
    sum    = {1'h0, acc_ff[0]} + {1'h0, hb} + {1'h0, carry_ff};
    if (i_ce) begin
      nxt_wrap = 1'h0;
      if (cnt_ff >= i_range_max) begin
        nxt_cnt  = 15'h0000;                                  // [R19]
        nxt_wrap = 1'h1;
      end else begin
        nxt_cnt = cnt_ff + 15'h0001;                          // [R19]
      end
      nxt_adv = cnt_ff == ref_ff;                             // [R10]
      if (adv_ff) begin
        nxt_gate = `TRGS_GATE_LEN;                            // [R14] [R11]
      end else if (gate_ff != 5'h00) begin
        nxt_gate = gate_ff - 5'h01;                           // [R11]
      end
      nxt_gopen = nxt_gate != 5'h00;
      nxt_fine  = fine_w;                                     // [R01]
      nxt_bin   = bin_ff | i_bin_tick;
      if (miss_ff == `TRGS_MISS_LIM) begin
        nxt_lock  = 1'h0;                                     // [R12] [R07]
        nxt_trial = 1'h0;
      end else if (wrap_ff) begin
        nxt_miss = miss_ff + 7'h01;                           // [R12]
      end
      if (push & push_rdy) begin
        nxt_acc  = '0;                                        // [R21]
        nxt_hits = 6'h00;                                     // [R20]
        nxt_bin  = i_bin_tick;
      end
      unique case (st_ff)
        trgs_pkg::ST_IDLE: begin
          // returns during a bin hand-over or an addition are dropped
          accept = ret & ~push & (~lock_ff | gopen_ff);       // [R11] [R07]
          if (accept) begin
            nxt_miss = 7'h00;                                 // [R12]
            // every hold bit, the fast group 9:6 included, loads here
            nxt_hold = {cnt_ff, sync2_ff[6:4], fine_w};       // [R03] [R18]
            if (!lock_ff) begin
              if (trial_ff && gopen_ff) begin
                nxt_lock = 1'h1;                              // [R13] [R08]
              end else begin
                nxt_trial = ~trial_ff;                        // [R13]
              end
            end
            nxt_step  = '0;
            nxt_carry = 1'h0;
            if (hits_ff != `TRGS_HIT_LIM) begin
              nxt_hits = hits_ff + 6'h01;                     // [R20]
              nxt_st   = trgs_pkg::ST_ADD;                    // [R15]
            end else begin
              nxt_st = trgs_pkg::ST_REDUCE;                   // [R20]
            end
          end
        end
        trgs_pkg::ST_ADD: begin
          nxt_acc   = {sum[0], acc_ff[ACC_W-1:1]};            // [R05] [R16]
          nxt_carry = sum[1];
          if (step_ff < SW'(HW)) begin
            nxt_hold = {hold_ff[0], hold_ff[HW-1:1]};         // [R02] [R18]
          end
          nxt_step = step_ff + 1'b1;
          if (step_ff == SW'(ACC_W - 1)) begin
            nxt_st = trgs_pkg::ST_REDUCE;
          end
        end
        trgs_pkg::ST_REDUCE: begin
          // sixteen counts, one whole gate length, never below zero
          if (hold_ff >= `TRGS_REDUCE) begin
            nxt_hold = hold_ff - `TRGS_REDUCE;                // [R06] [R14]
          end else begin
            nxt_hold = '0;                                    // [R09]
          end
          nxt_ref = nxt_hold[HW-1:`TRGS_FINE_W];              // [R10]
          nxt_st  = trgs_pkg::ST_IDLE;                        // [R04]
        end
      endcase
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      st_ff    <= trgs_pkg::ST_IDLE;
      cnt_ff   <= 15'h0000;
      ref_ff   <= 15'h0000;
      wrap_ff  <= 1'h0;
      adv_ff   <= 1'h0;
      gate_ff  <= 5'h00;
      gopen_ff <= 1'h0;
      trial_ff <= 1'h0;                                       // [R07]
      lock_ff  <= 1'h0;                                       // [R07]
      miss_ff  <= 7'h00;
      hold_ff  <= '0;
      acc_ff   <= '0;
      carry_ff <= 1'h0;
      step_ff  <= '0;
      hits_ff  <= 6'h00;
      bin_ff   <= 1'h0;
      fine_ff  <= 3'h0;
    end else begin
      st_ff    <= nxt_st;
      cnt_ff   <= nxt_cnt;
      ref_ff   <= nxt_ref;
      wrap_ff  <= nxt_wrap;
      adv_ff   <= nxt_adv;
      gate_ff  <= nxt_gate;
      gopen_ff <= nxt_gopen;
      trial_ff <= nxt_trial;
      lock_ff  <= nxt_lock;
      miss_ff  <= nxt_miss;
      hold_ff  <= nxt_hold;
      acc_ff   <= nxt_acc;
      carry_ff <= nxt_carry;
      step_ff  <= nxt_step;
      hits_ff  <= nxt_hits;
      bin_ff   <= nxt_bin;
      fine_ff  <= nxt_fine;
    end
  end

  // a full store holds the bin pending, which in turn stalls returns
  logic [ACC_W-1:0] avg_w;

  trgs_fifo #(
    .W     (ACC_W),
    .DEPTH (DEPTH)
  ) u_fifo (
    .i_clk   (i_ref_clk),
    .i_rst   (i_rst),
    .i_ce    (i_ce),
    .i_valid (push),
    .o_ready (push_rdy),
    .i_data  (acc_ff),
    .o_valid (o_avg_valid),
    .o_data  (avg_w),
    .i_ready (i_avg_ready)
  );

  assign o_avg               = avg_w[ACC_W-1:AL];             // [R17]
  assign o_avg_frac          = avg_w[AL-1:0];                 // [R17]
  assign o_range_count       = cnt_ff;
  assign o_range_wrap        = wrap_ff;
  assign o_hold              = hold_ff;
  assign o_gate_open         = gopen_ff;
  assign o_trial_gate_flag   = trial_ff;
  assign o_gate_lock_flag    = lock_ff;
  assign o_gate_advance_flag = adv_ff;
  assign o_fine_code         = fine_ff;
  assign o_hits              = hits_ff;
  assign o_miss              = miss_ff;

endmodule : trgs_top

// >>> trgs_defs.svh
// trgs_defs.svh: widths, field positions and counts of the range gate
// and smoother; included only by trgs_top, not by the other design files
`ifndef TRGS_DEFS_SVH
`define TRGS_DEFS_SVH

`define TRGS_CNT_W       15
`define TRGS_FINE_W      6
`define TRGS_HOLD_W      21
`define TRGS_ACC_W       26
`define TRGS_AVG_LSB     5
`define TRGS_FIFO_DEPTH  8
`define TRGS_SYNC_W      8
// 102.4 m: 16 coarse counts of 6.4 m, placed above the six fine bits
`define TRGS_REDUCE      21'h000400
`define TRGS_GATE_LEN    5'h10
`define TRGS_MISS_LIM    7'h40
`define TRGS_HIT_LIM     6'h20

`endif

// >>> trgs_pkg.sv
// trgs_pkg: types shared by the range gate and smoother
// needs no trgs_defs.svh constants; the state codes are written inline
package trgs_pkg;

  // gray steps idle -> add -> reduce; reduce -> idle changes both bits
  typedef enum logic [1:0] {
    ST_IDLE   = 2'h0,
    ST_ADD    = 2'h1,
    ST_REDUCE = 2'h3
  } trgs_state_e;

endpackage : trgs_pkg

// >>> trgs_fine_dec.sv
// trgs_fine_dec: thermometer phase flags to the three low fine bits
// assumes flags already synchronised to the logic clock
`timescale 1ns/1ps
module trgs_fine_dec (
  input  wire logic       i_phase_flag_a, // first tap flag
  input  wire logic       i_phase_flag_b, // second tap flag
  input  wire logic       i_phase_flag_c, // third tap flag
  input  wire logic       i_phase_flag_d, // fourth tap flag
  output logic      [2:0] o_code          // {hi, mid, lo}
);
  logic a, b, c, d;
  logic fine_code_hi, fine_code_mid, fine_code_lo;

  always_comb begin
    a = i_phase_flag_a;
    b = i_phase_flag_b;
    c = i_phase_flag_c;
    d = i_phase_flag_d;
    fine_code_hi  = d;                                        // [R01]
    fine_code_mid = (a & b & ~d) | (~a & ~b & d);             // [R01]
    fine_code_lo  = (a & ~b & ~c & ~d) | (a & b & c & ~d)
                  | (~a & b & c & d) | (~a & ~b & ~c & d);    // [R01]
    o_code = {fine_code_hi, fine_code_mid, fine_code_lo};
  end

endmodule : trgs_fine_dec

// >>> trgs_fifo.sv
// trgs_fifo: valid/ready FIFO with a registered output word
// assumes one clock and a clock enable shared with the writer
`timescale 1ns/1ps
module trgs_fifo #(
  parameter int W     = 26,
  parameter int DEPTH = 8
) (
  input  wire logic         i_clk,   // logic clock
  input  wire logic         i_rst,   // sync reset, high
  input  wire logic         i_ce,    // freezes all state when low
  input  wire logic         i_valid, // writer offers a word
  output logic              o_ready, // room in the store
  input  wire logic [W-1:0] i_data,  // word written
  output logic              o_valid, // output word present
  output logic      [W-1:0] o_data,  // output word
  input  wire logic         i_ready  // reader takes the word
);
  localparam int AW = $clog2(DEPTH);

  generate
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
      $error("trgs_fifo: DEPTH must be a power of two, at least 2");
    end
  endgenerate

  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] wr_ff, rd_ff, nxt_wr, nxt_rd;
  logic [AW:0]   cnt_ff, nxt_cnt;
  logic          val_ff, nxt_val;
  logic [W-1:0]  dat_ff, nxt_dat;
  logic          push, pop;

  always_comb begin
    o_ready = cnt_ff != (AW+1)'(DEPTH);
    push    = i_ce & i_valid & o_ready;
    // the output stage refills whenever it is empty or being taken
    pop     = i_ce & (cnt_ff != '0) & (~val_ff | i_ready);
    nxt_wr  = push ? wr_ff + 1'b1 : wr_ff;
    nxt_rd  = pop ? rd_ff + 1'b1 : rd_ff;
    nxt_cnt = cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
    nxt_val = val_ff;
    nxt_dat = dat_ff;
    if (pop) begin
      nxt_val = 1'b1;
      nxt_dat = mem[rd_ff];
    end else if (i_ce & i_ready) begin
      nxt_val = 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      wr_ff  <= '0;
      rd_ff  <= '0;
      cnt_ff <= '0;
      val_ff <= 1'b0;
      dat_ff <= '0;
    end else begin
      wr_ff  <= nxt_wr;
      rd_ff  <= nxt_rd;
      cnt_ff <= nxt_cnt;
      val_ff <= nxt_val;
      dat_ff <= nxt_dat;
    end
  end

  always_ff @(posedge i_clk) begin
    if (push) begin
      mem[wr_ff] <= i_data;
    end
  end

  assign o_valid = val_ff;
  assign o_data  = dat_ff;

endmodule : trgs_fifo

// >>> trgs_top_monitor.sv
// trgs_top_monitor: port timing checks for trgs_top
// assumes one clock and a synchronous active-high reset
`timescale 1ns/1ps
module trgs_top_monitor #(
  parameter int ACC_W = 26
) (
  input wire logic             i_ref_clk,           // clock
  input wire logic             i_rst,               // reset
  input wire logic             i_ce,                // enable
  input wire logic [14:0]      i_range_max,         // wrap count
  input wire logic             i_avg_ready,         // reader
  input wire logic             o_avg_valid,         // word out
  input wire logic [ACC_W-6:0] o_avg,               // average
  input wire logic [14:0]      o_range_count,       // coarse
  input wire logic             o_range_wrap,        // wrap
  input wire logic             o_gate_open,         // gate
  input wire logic             o_trial_gate_flag,   // trial
  input wire logic             o_gate_lock_flag,    // lock
  input wire logic             o_gate_advance_flag, // advance
  input wire logic [5:0]       o_hits,              // hits
  input wire logic [6:0]       o_miss               // misses
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  // counted here: a sixteen-fold repetition would be slow to unroll
  logic [5:0] gate_run_ff;
  logic [5:0] nxt_gate_run;
  always_comb begin
    nxt_gate_run = gate_run_ff;
    if (i_ce)
      nxt_gate_run = o_gate_open ? gate_run_ff + 6'h01 : 6'h00;
  end
  always_ff @(posedge i_ref_clk) begin
    if (i_rst)
      gate_run_ff <= 6'h00;
    else
      gate_run_ff <= nxt_gate_run;
  end
  sequence s_adv;
    i_ce && o_gate_advance_flag;
  endsequence
  sequence s_miss_full;
    i_ce && o_miss == 7'h40 ##1 o_miss == 7'h40;
  endsequence
  chk_count_step: assert property (
    i_ce && o_range_count < i_range_max
    |=> o_range_count == $past(o_range_count) + 15'h0001)
    else $error("coarse count did not step");
  chk_count_wrap: assert property (
    i_ce && o_range_count >= i_range_max |=> o_range_count == 15'h0000)
    else $error("coarse count did not wrap");
  chk_wrap_pulse: assert property (
    o_range_wrap && $past(i_ce)
    |-> o_range_count == 15'h0000
        && $past(o_range_count) >= $past(i_range_max))
    else $error("wrap pulse out of place");
  chk_gate_len: assert property (
    $fell(o_gate_open) |-> gate_run_ff == 6'h10)
    else $error("gate length wrong");
  chk_adv_opens: assert property (s_adv |=> o_gate_open)
    else $error("gate did not open after advance");
  chk_miss_unlock: assert property (
    s_miss_full |-> !o_gate_lock_flag && !o_trial_gate_flag)
    else $error("flags kept after miss limit");
  chk_miss_clear: assert property (
    o_hits == $past(o_hits) + 6'h01 |-> o_miss == 7'h00)
    else $error("miss count not cleared on return");
  chk_hits_step: assert property (
    o_hits != $past(o_hits)
    |-> o_hits == $past(o_hits) + 6'h01 || o_hits == 6'h00)
    else $error("hit count jumped");
  chk_avg_stand: assert property (
    i_ce && o_avg_valid && !i_avg_ready |=> o_avg_valid && $stable(o_avg))
    else $error("average word dropped");
endmodule : trgs_top_monitor

bind trgs_top trgs_top_monitor #(.ACC_W(ACC_W)) u_mon (
  .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_ce(i_ce),
  .i_range_max(i_range_max), .i_avg_ready(i_avg_ready),
  .o_avg_valid(o_avg_valid), .o_avg(o_avg),
  .o_range_count(o_range_count), .o_range_wrap(o_range_wrap),
  .o_gate_open(o_gate_open), .o_trial_gate_flag(o_trial_gate_flag),
  .o_gate_lock_flag(o_gate_lock_flag),
  .o_gate_advance_flag(o_gate_advance_flag),
  .o_hits(o_hits), .o_miss(o_miss)
);

// >>> trgs_echo_model.sv
// trgs_echo_model: threshold detector and tap counter of one return
// assumes i_fire is a one-cycle request driven just after an edge
`timescale 1ns/1ps
module trgs_echo_model (
  input  wire logic       i_clk,          // logic clock
  input  wire logic       i_fire,         // start one return
  input  wire logic [5:0] i_code,         // {tap, low fine}
  output logic            o_echo,         // threshold level
  output logic            o_phase_flag_a, // tap flag
  output logic            o_phase_flag_b, // tap flag
  output logic            o_phase_flag_c, // tap flag
  output logic            o_phase_flag_d, // tap flag
  output logic      [2:0] o_tap           // tap counter
);
  int         age = 99;
  logic [5:0] code = 6'h00;
  logic [3:0] therm;
  always @(posedge i_clk) begin
    if (i_fire) begin
      code <= i_code;
      age <= 0;
    end else if (age < 99)
      age <= age + 1;
  end
  always_comb begin
    case (code[2:0]) // thermometer order of the four flags
      3'h1: therm = 4'h8;
      3'h2: therm = 4'hC;
      3'h3: therm = 4'hE;
      3'h4: therm = 4'hF;
      3'h5: therm = 4'h7;
      3'h6: therm = 4'h3;
      3'h7: therm = 4'h1;
      default: therm = 4'h0;
    endcase
  end
  assign o_echo = (age < 4);
  // flags fall back to zero and the tap bits read inverted between frames
  assign {o_phase_flag_a, o_phase_flag_b, o_phase_flag_c, o_phase_flag_d}
    = (age < 10) ? therm : 4'h0;
  assign o_tap = (age < 10) ? code[5:3] : ~code[5:3];
endmodule : trgs_echo_model

// >>> trgs_top_tb.sv
// trgs_top_tb: self-checking bench for trgs_top
// assumes trgs_echo_model drives the echo, phase flag and tap pins
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin \
  num_errors++; $display("wrong value at %0t: got %h want %h", \
  $time, g, e); end end
module trgs_top_tb;
  localparam int RMAX = 199;
  logic        clk, rst, ce, fire, bin_tick, avg_ready;
  logic        echo, fa, fb, fc, fd, avg_valid, trial, lock;
  logic [2:0]  tap, fine;
  logic [4:0]  frac;
  logic [5:0]  code, hits;
  logic [6:0]  miss;
  logic [14:0] cnt;
  logic [20:0] avg, hold, cap, rexp;
  logic [25:0] sum;
  logic [25:0] words[$];
  int          num_errors, cmp_count, mcnt, lat, at;

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  trgs_top #(.ACC_W(26), .DEPTH(8)) dut (
    .i_ref_clk(clk), .i_rst(rst), .i_ce(ce),
    .i_phase_flag_a(fa), .i_phase_flag_b(fb),
    .i_phase_flag_c(fc), .i_phase_flag_d(fd),
    .i_fine_tap(tap), .i_echo(echo), .i_range_max(15'(RMAX)),
    .i_bin_tick(bin_tick), .i_avg_ready(avg_ready),
    .o_avg_valid(avg_valid), .o_avg(avg), .o_avg_frac(frac),
    .o_range_count(cnt), .o_range_wrap(), .o_hold(hold),
    .o_gate_open(), .o_trial_gate_flag(trial),
    .o_gate_lock_flag(lock), .o_gate_advance_flag(),
    .o_fine_code(fine), .o_hits(hits), .o_miss(miss)
  );
  trgs_echo_model u_src (
    .i_clk(clk), .i_fire(fire), .i_code(code), .o_echo(echo),
    .o_phase_flag_a(fa), .o_phase_flag_b(fb), .o_phase_flag_c(fc),
    .o_phase_flag_d(fd), .o_tap(tap)
  );
  always @(posedge clk) begin
    if (rst)
      mcnt <= 0;
    else if (ce)
      mcnt <= (mcnt >= RMAX) ? 0 : mcnt + 1;
  end
  always @(negedge clk) begin
    if (rst === 1'b0)
      `CHK(cnt, 15'(mcnt))
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic wait_cnt(input int c);
    int g;
    g = 0;
    while (mcnt != c && g < 1000) begin
      tick(1);
      g++;
    end
  endtask : wait_cnt
  task automatic shoot();
    fire = 1'b1;
    tick(1);
    fire = 1'b0;
  endtask : shoot
  task automatic summarize();
    $display("checks %0d errors %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : summarize

  initial begin
    repeat (60000) @(posedge clk);
    num_errors++;
    summarize();
  end
  initial begin
    void'($urandom(62006));
    rst = 1'b1;
    ce = 1'b1;
    fire = 1'b0;
    bin_tick = 1'b0;
    avg_ready = 1'b0;
    code = 6'h00;
    tick(20);
    rst = 1'b0;
    tick(1);
    `CHK(lock, 1'b0)
    sum = 26'h0;
    at = 100;
    // one model edge, two sync stages: capture sees the count three on
    lat = 3;
    // spacing of 70..90 counts keeps every return outside the trial gate
    for (int k = 0; k < 33; k++) begin
      code = {3'($urandom), (k < 8) ? 3'(k) : 3'($urandom)};
      wait_cnt(at);
      if (k > 0)
        `CHK(hold, rexp)
      shoot();
      tick(5);
      `CHK(fine, code[2:0])
      tick(40);
      cap = {15'((at + lat) % (RMAX + 1)), code};
      rexp = (cap >= 21'h000400) ? cap - 21'h000400 : 21'h000000;
      if (k < 32)
        sum += 26'(cap);
      `CHK(hold, rexp)
      `CHK(hits, 6'(k < 32 ? k + 1 : 32))
      `CHK(trial, 1'(k % 2 == 0))
      `CHK(lock, 1'b0)
      at = (at + 70 + $urandom_range(20)) % (RMAX + 1);
    end
    `CHK(avg_valid, 1'b0)
    repeat (10) begin
      bin_tick = 1'b1;
      tick(1);
      bin_tick = 1'b0;
      tick(5);
    end
    `CHK(avg_valid, 1'b1)
    `CHK({avg, frac}, sum)
    wait_cnt(20);
    shoot();
    tick(40);
    `CHK(hits, 6'h00)
    repeat (300) begin
      avg_ready = 1'($urandom);
      @(negedge clk);
      if (avg_valid === 1'b1 && avg_ready === 1'b1)
        words.push_back({avg, frac});
      tick(1);
    end
    `CHK(32'(words.size()), 32'h0000000A)
    foreach (words[i])
      `CHK(words[i], (i == 0) ? sum : 26'h0)
    rst = 1'b1;
    tick(3);
    rst = 1'b0;
    code = 6'h2D;
    wait_cnt(3);
    shoot();
    tick(40);
    `CHK(hold, 21'h000000)
    `CHK(trial, 1'b1)
    wait_cnt(3);
    shoot();
    tick(40);
    `CHK(lock, 1'b1)
    wait_cnt(150);
    shoot();
    tick(40);
    `CHK(hits, 6'h02)
    wait_cnt(50);
    ce = 1'b0;
    tick(10);
    ce = 1'b1;
    tick(66 * (RMAX + 1));
    `CHK(miss, 7'h40)
    `CHK(lock, 1'b0)
    summarize();
  end
endmodule : trgs_top_tb
